// file: design/max_address_limit_security.sv
// maximum-address-limit command interpreter with its security extensions
`timescale 1ns/1ps
module max_address_limit_security
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        powerOn,
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [15:0]      regRdData,
  input  wire logic [27:0] accessAddr,
  input  wire logic        accessReq,
  output logic             accessAbort,
  output logic [27:0]      identifyMax,
  output logic             busy
);
  import max_limit_pkg::*;
  typedef enum logic [1:0] {ST_IDLE, ST_DECODE, ST_DATA} phase_t;
  typedef struct packed {
    phase_t      phase;
    logic [7:0]  feature;
    logic [7:0]  secCount;
    logic [7:0]  secNum;
    logic [7:0]  cylLo;
    logic [7:0]  cylHi;
    logic [7:0]  head;
    logic [7:0]  command;
    logic [7:0]  errFlags;
    logic [7:0]  status;
    logic [27:0] maxAddr;
    logic [27:0] nvMaxAddr;
    logic        nvValid;
    logic        nvUsed;
    logic        afterNative;
    logic        offsetMode;
    sec_state_t  secState;
    logic [7:0]  wordCnt;
    logic        pwSet;
    logic        accAbort;
    logic [15:0] rdData;
  } core_t;
  core_t st_ff;
  core_t nxt_st;
  logic        pwValid;
  logic        pwStart;
  logic        pwMatch;
  logic [27:0] newLimit;
  logic        isLba;
  logic        limitCmd;
  assign isLba = st_ff.head[HEAD_LBA_BIT];
  // new limit: LBA spread over four registers, CHS from cylinders only
  assign newLimit = isLba ? {st_ff.head[3:0], st_ff.cylHi, st_ff.cylLo, st_ff.secNum} // R10
                          : {12'h000, st_ff.cylHi, st_ff.cylLo};                    // R11
  assign limitCmd = st_ff.afterNative; // R2
  assign pwValid  = regWr && (regAddr == REG_DATA) && (st_ff.phase == ST_DATA);
  assign pwStart  = (st_ff.phase == ST_DECODE);
  password_store u_pass
  (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .wordValid  (pwValid),
    .wordIndex  (st_ff.wordCnt),
    .wordData   (regWrData),
    .storeMode  (st_ff.feature == FEAT_SET_PASS),
    .startFrame (pwStart),
    .matchAll   (pwMatch)
  );
  // command decode and state tracking
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.accAbort = 1'b0;
    nxt_st.rdData = '0;
    if (regRd)
    begin
      unique case (regAddr)
        REG_ERROR:   nxt_st.rdData = {8'h00, st_ff.errFlags};
        REG_SECCNT:  nxt_st.rdData = {8'h00, st_ff.secCount};
        REG_SECNUM:  nxt_st.rdData = {8'h00, st_ff.secNum};
        REG_CYLLO:   nxt_st.rdData = {8'h00, st_ff.cylLo};
        REG_CYLHI:   nxt_st.rdData = {8'h00, st_ff.cylHi};
        REG_HEAD:    nxt_st.rdData = {8'h00, st_ff.head};
        REG_STATUS:  nxt_st.rdData = {8'h00, st_ff.status};
        REG_FEATURE: nxt_st.rdData = {8'h00, st_ff.feature};
        REG_LIMSTAT: nxt_st.rdData = {11'h000, st_ff.pwSet, st_ff.nvUsed, st_ff.afterNative,
                                      st_ff.secState};
        REG_OFFMODE: nxt_st.rdData = {15'h0000, st_ff.offsetMode};
        default:     nxt_st.rdData = '0;
      endcase
    end
    if (regWr && st_ff.phase == ST_IDLE)
    begin
      unique case (regAddr)
        REG_FEATURE: nxt_st.feature  = regWrData[7:0];
        REG_SECCNT:  nxt_st.secCount = regWrData[7:0];
        REG_SECNUM:  nxt_st.secNum   = regWrData[7:0];
        REG_CYLLO:   nxt_st.cylLo    = regWrData[7:0];
        REG_CYLHI:   nxt_st.cylHi    = regWrData[7:0];
        REG_HEAD:    nxt_st.head     = regWrData[7:0];
        REG_OFFMODE: nxt_st.offsetMode = regWrData[0];
        REG_STATUS:
        begin
          nxt_st.command = regWrData[7:0];
          nxt_st.status  = 8'h00;
          nxt_st.status[STS_BUSY_BIT] = 1'b1;
          nxt_st.errFlags = 8'h00;
          if (regWrData[7:0] == CMD_LIMIT)  // R1
            nxt_st.phase = ST_DECODE;
          else
          begin
            // other commands finish at once; only native-max marks the flag
            nxt_st.afterNative = (regWrData[7:0] == CMD_READ_NATIVE); // R19
            nxt_st.status = 8'h00;
            nxt_st.status[STS_READY_BIT] = 1'b1;
            if (regWrData[7:0] == CMD_READ_NATIVE)
            begin
              nxt_st.secNum = st_ff.maxAddr[7:0];
              nxt_st.cylLo  = st_ff.maxAddr[15:8];
              nxt_st.cylHi  = st_ff.maxAddr[23:16];
              nxt_st.head   = {st_ff.head[7:4], st_ff.maxAddr[27:24]};
            end
          end
        end
        default: ;
      endcase
    end
    unique case (st_ff.phase)
      ST_IDLE: ;
      ST_DECODE:
      begin
        nxt_st.afterNative = 1'b0; // R19
        nxt_st.phase  = ST_IDLE;
        nxt_st.status = 8'h00;
        nxt_st.status[STS_READY_BIT] = 1'b1; // busy cleared on finish
        if (limitCmd)
        begin
          if (st_ff.secState != SEC_UNLOCKED                     // R8
              || (st_ff.secCount[VOL_BIT] && st_ff.offsetMode)   // R6
              || (st_ff.secCount[VOL_BIT] && st_ff.nvUsed)       // R7
              || newLimit > NATIVE_MAX_RST)                      // R4
          begin
            nxt_st.errFlags[ERR_ABORT_BIT] = 1'b1; // R20
            nxt_st.status[STS_ERR_BIT] = 1'b1;
          end
          else
          begin
            nxt_st.maxAddr = newLimit; // R4
            if (st_ff.secCount[VOL_BIT]) // R9
            begin
              nxt_st.nvMaxAddr = newLimit;
              nxt_st.nvValid   = 1'b1;
              nxt_st.nvUsed    = 1'b1;
            end
            if (isLba)
            begin
              nxt_st.secNum = newLimit[7:0]; // R12
              nxt_st.cylLo  = newLimit[15:8];
              nxt_st.cylHi  = newLimit[23:16];
              nxt_st.head   = {st_ff.head[7:4], newLimit[27:24]};
            end
            else
            begin
              nxt_st.secNum = MAX_SECTOR_RST; // R13
              nxt_st.head   = {st_ff.head[7:4], MAX_HEAD_RST};
            end
          end
        end
        else
        begin
          unique case (st_ff.feature) // R3
            FEAT_SET_PASS, FEAT_UNLOCK:
            begin
              if (st_ff.secState == SEC_FROZEN
                  || (st_ff.feature == FEAT_SET_PASS && st_ff.secState == SEC_LOCKED)) // R17
              begin
                nxt_st.errFlags[ERR_ABORT_BIT] = 1'b1; // R20
                nxt_st.status[STS_ERR_BIT] = 1'b1;
              end
              else
              begin
                nxt_st.phase = ST_DATA; // R14
                nxt_st.wordCnt = '0;
                nxt_st.status = 8'h00;
                nxt_st.status[STS_BUSY_BIT] = 1'b0;
                nxt_st.status[STS_REQ_BIT]  = 1'b1;
              end
            end
            FEAT_LOCK:
            begin
              if (st_ff.secState != SEC_UNLOCKED) // R17
              begin
                nxt_st.errFlags[ERR_ABORT_BIT] = 1'b1; // R20
                nxt_st.status[STS_ERR_BIT] = 1'b1;
              end
              else
                nxt_st.secState = SEC_LOCKED; // R17
            end
            FEAT_FREEZE:
            begin
              if (st_ff.secState == SEC_FROZEN)
              begin
                nxt_st.errFlags[ERR_ABORT_BIT] = 1'b1; // R20
                nxt_st.status[STS_ERR_BIT] = 1'b1;
              end
              else
                nxt_st.secState = SEC_FROZEN; // R18
            end
            default:
            begin
              nxt_st.errFlags[ERR_ABORT_BIT] = 1'b1; // R20
              nxt_st.status[STS_ERR_BIT] = 1'b1;
            end
          endcase
        end
      end
      ST_DATA:
      begin
        if (pwValid)
          nxt_st.wordCnt = st_ff.wordCnt + 8'd1;
        if (pwValid && st_ff.wordCnt == 8'(SECTOR_WORDS - 1))
        begin
          nxt_st.phase  = ST_IDLE;
          nxt_st.status = 8'h00;
          nxt_st.status[STS_READY_BIT] = 1'b1;
          if (st_ff.feature == FEAT_SET_PASS)
          begin
            nxt_st.pwSet    = 1'b1;
            nxt_st.secState = SEC_UNLOCKED; // R16
          end
          else if (pwMatch && st_ff.pwSet)
            nxt_st.secState = SEC_UNLOCKED; // R18
          else
          begin
            nxt_st.errFlags[ERR_ABORT_BIT] = 1'b1; // R20
            nxt_st.status[STS_ERR_BIT] = 1'b1;
          end
        end
      end
      default: nxt_st.phase = ST_IDLE;
    endcase
    // accesses beyond the limit are refused
    if (accessReq && accessAddr > st_ff.maxAddr)
      nxt_st.accAbort = 1'b1; // R4
  end
  // hardware reset clears all but ready status and the limits (native maximum); power-on keeps a nonvolatile limit
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      st_ff <= '0;
      st_ff.status  <= 8'h40;
      st_ff.maxAddr <= NATIVE_MAX_RST;
      st_ff.nvMaxAddr <= NATIVE_MAX_RST;
    end
    else if (powerOn)
    begin
      st_ff <= '0; // R9
      st_ff.status  <= 8'h40;
      st_ff.maxAddr <= st_ff.nvValid ? st_ff.nvMaxAddr : NATIVE_MAX_RST; // R9
      st_ff.nvMaxAddr <= st_ff.nvMaxAddr;
      st_ff.nvValid <= st_ff.nvValid;
    end
    else
      st_ff <= nxt_st;
  end
  assign regRdData   = st_ff.rdData;
  assign accessAbort = st_ff.accAbort;
  assign identifyMax = st_ff.maxAddr; // R5
  assign busy        = st_ff.status[STS_BUSY_BIT];
  // checks
  property p_lock_blocks_limit;
    @(posedge clk_sys) disable iff (!reset_n)
    (st_ff.phase == ST_DECODE && limitCmd && st_ff.secState != SEC_UNLOCKED)
      |=> (st_ff.errFlags[ERR_ABORT_BIT] && $stable(st_ff.maxAddr));
  endproperty
  a_lock_blocks_limit: assert property (p_lock_blocks_limit) // R8
    else $error("limit changed while locked");
  property p_abort_status;
    @(posedge clk_sys) disable iff (!reset_n)
    $rose(st_ff.errFlags[ERR_ABORT_BIT]) |-> (st_ff.status[STS_ERR_BIT] && !busy);
  endproperty
  a_abort_status: assert property (p_abort_status) // R20
    else $error("abort without error status");
  property p_access_beyond;
    @(posedge clk_sys) disable iff (!reset_n || powerOn)
    (accessReq && accessAddr > st_ff.maxAddr) |=> accessAbort;
  endproperty
  a_access_beyond: assert property (p_access_beyond) // R4
    else $error("access beyond limit not refused");
  property p_capacity;
    @(posedge clk_sys) disable iff (!reset_n)
    (st_ff.phase == ST_DECODE && limitCmd && newLimit > NATIVE_MAX_RST)
      |=> (st_ff.errFlags[ERR_ABORT_BIT] && $stable(st_ff.maxAddr));
  endproperty
  a_capacity: assert property (p_capacity) // R4
    else $error("limit beyond capacity not aborted");
  property p_offset_nv_abort;
    @(posedge clk_sys) disable iff (!reset_n)
    (st_ff.phase == ST_DECODE && limitCmd && st_ff.secCount[VOL_BIT] && st_ff.offsetMode)
      |=> st_ff.errFlags[ERR_ABORT_BIT];
  endproperty
  a_offset_nv_abort: assert property (p_offset_nv_abort) // R6
    else $error("nonvolatile update in offset mode not aborted");
  property p_nv_once;
    @(posedge clk_sys) disable iff (!reset_n)
    (st_ff.phase == ST_DECODE && limitCmd && st_ff.secCount[VOL_BIT] && st_ff.nvUsed)
      |=> (st_ff.errFlags[ERR_ABORT_BIT] && $stable(st_ff.maxAddr));
  endproperty
  a_nv_once: assert property (p_nv_once) // R7
    else $error("second nonvolatile update not aborted");
  property p_native_clear;
    @(posedge clk_sys) disable iff (!reset_n)
    (st_ff.phase == ST_DECODE) |=> !st_ff.afterNative;
  endproperty
  a_native_clear: assert property (p_native_clear) // R19
    else $error("read-native flag survived a decode");
  property p_frozen_holds;
    @(posedge clk_sys) disable iff (!reset_n)
    (st_ff.secState == SEC_FROZEN && reset_n && !powerOn) |=> (st_ff.secState == SEC_FROZEN);
  endproperty
  a_frozen_holds: assert property (p_frozen_holds) // R18
    else $error("frozen state left without a power cycle");
  property p_setpw_locked;
    @(posedge clk_sys) disable iff (!reset_n)
    (st_ff.phase == ST_DECODE && !limitCmd && st_ff.feature == FEAT_SET_PASS
     && st_ff.secState == SEC_LOCKED)
      |=> (st_ff.errFlags[ERR_ABORT_BIT] && st_ff.phase == ST_IDLE);
  endproperty
  a_setpw_locked: assert property (p_setpw_locked) // R17
    else $error("set-password accepted while locked");
  property p_lba_return;
    @(posedge clk_sys) disable iff (!reset_n)
    (st_ff.phase == ST_DECODE && limitCmd && isLba && st_ff.secState == SEC_UNLOCKED
     && !st_ff.secCount[VOL_BIT] && newLimit <= NATIVE_MAX_RST)
      |=> ({st_ff.head[3:0], st_ff.cylHi, st_ff.cylLo, st_ff.secNum} == st_ff.maxAddr);
  endproperty
  a_lba_return: assert property (p_lba_return) // R12
    else $error("block-mode limit not returned in task file");
  property p_chs_return;
    @(posedge clk_sys) disable iff (!reset_n)
    (st_ff.phase == ST_DECODE && limitCmd && !isLba && st_ff.secState == SEC_UNLOCKED
     && !st_ff.secCount[VOL_BIT])
      |=> (st_ff.secNum == MAX_SECTOR_RST && st_ff.head[3:0] == MAX_HEAD_RST);
  endproperty
  a_chs_return: assert property (p_chs_return) // R13
    else $error("cylinder-mode maxima not returned");
  property p_busy_decode;
    @(posedge clk_sys) disable iff (!reset_n)
    (st_ff.phase == ST_DECODE) |-> (busy ##1 !busy);
  endproperty
  a_busy_decode: assert property (p_busy_decode) // R1
    else $error("busy not shown for exactly the decode cycle");
endmodule

// file: design/max_limit_pkg.sv
// constants for the maximum-address-limit command block
//
// Overview of operation
// R1: opcode F9h selects the maximum-address-limit command family.
// R2: directly after read-native-maximum, the command is always a limit update.
// R3: otherwise feature 01h password, 02h lock, 03h unlock, 04h freeze.
// R4: new limit replaces maximum within capacity; accesses beyond it abort.
// R5: identify reports the newly set limit as default capacity.
// R6: nonvolatile update in address offset mode aborts.
// R7: second nonvolatile update aborts until power-on or hardware reset.
// R8: limit update aborts while locked or frozen.
// R9: volatility bit 1 keeps limit across power-on; 0 loses it.
// R10: host supplies LBA bits over sector, cylinder low, high, head nibble.
// R11: CHS mode takes limit from cylinder registers only.
// R12: LBA completion returns limit over sector, cylinders and head nibble.
// R13: CHS completion returns maximum sector, cylinder and head.
// R14: set-password sends one sector; words 1-16 hold the 32-byte password.
// R15: password is held only until the next power cycle.
// R16: accepting set-password leaves the device unlocked.
// R17: lock enters locked state; only unlock and freeze are then allowed.
// R18: locked persists until power cycle, accepted unlock or freeze.
// R19: flag marks last command was read-native-maximum; others clear it.
// R20: abort sets abort and error bits, clears busy, keeps state.
package max_limit_pkg;
  localparam logic [7:0] CMD_LIMIT       = 8'hF9;
  localparam logic [7:0] CMD_READ_NATIVE = 8'hF8;
  localparam logic [7:0] FEAT_SET_PASS   = 8'h01;
  localparam logic [7:0] FEAT_LOCK       = 8'h02;
  localparam logic [7:0] FEAT_UNLOCK     = 8'h03;
  localparam logic [7:0] FEAT_FREEZE     = 8'h04;
  localparam int         ERR_ABORT_BIT   = 2;
  localparam int         STS_ERR_BIT     = 0;
  localparam int         STS_READY_BIT   = 6;
  localparam int         STS_BUSY_BIT    = 7;
  localparam int         STS_REQ_BIT     = 3;
  localparam int         HEAD_LBA_BIT    = 6;
  localparam int         VOL_BIT         = 0;
  localparam int         PASS_FIRST_WORD = 1;
  localparam int         PASS_LAST_WORD  = 16;
  localparam int         SECTOR_WORDS    = 256;
  localparam logic [27:0] NATIVE_MAX_RST = 28'h0FF_FFFF;
  localparam logic [7:0]  MAX_SECTOR_RST = 8'h3F;
  localparam logic [3:0]  MAX_HEAD_RST   = 4'hF;
  // register offsets of the plain register port
  localparam logic [3:0] REG_DATA    = 4'h0;
  localparam logic [3:0] REG_ERROR   = 4'h1;
  localparam logic [3:0] REG_SECCNT  = 4'h2;
  localparam logic [3:0] REG_SECNUM  = 4'h3;
  localparam logic [3:0] REG_CYLLO   = 4'h4;
  localparam logic [3:0] REG_CYLHI   = 4'h5;
  localparam logic [3:0] REG_HEAD    = 4'h6;
  localparam logic [3:0] REG_STATUS  = 4'h7;
  localparam logic [3:0] REG_FEATURE = 4'h8;
  localparam logic [3:0] REG_LIMSTAT = 4'h9;
  localparam logic [3:0] REG_OFFMODE = 4'hA;
  typedef enum logic [1:0] {SEC_UNLOCKED, SEC_LOCKED, SEC_FROZEN} sec_state_t;
endpackage

// file: design/password_store.sv
// password word store with set and compare paths
`timescale 1ns/1ps
module password_store
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        wordValid,
  input  wire logic [7:0]  wordIndex,
  input  wire logic [15:0] wordData,
  input  wire logic        storeMode,
  input  wire logic        startFrame,
  output logic             matchAll
);
  import max_limit_pkg::*;
  typedef struct packed {
    logic [15:0][15:0] words;
    logic              match;
  } pw_state_t;
  pw_state_t st_ff;
  pw_state_t nxt_st;
  logic      inPass;
  assign inPass = (wordIndex >= 8'(PASS_FIRST_WORD)) && (wordIndex <= 8'(PASS_LAST_WORD));
  // store on set, compare on unlock; volatile until reset
  always_comb
  begin
    nxt_st = st_ff;
    if (startFrame)
      nxt_st.match = 1'b1;
    if (wordValid && inPass)
    begin
      if (storeMode)
        nxt_st.words[4'(wordIndex - 8'd1)] = wordData; // R14
      else if (st_ff.words[4'(wordIndex - 8'd1)] != wordData)
        nxt_st.match = 1'b0;
    end
  end
  // hardware reset clears the password; power-on does not reach this store
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      st_ff <= '0; // R15
    else
      st_ff <= nxt_st;
  end
  assign matchAll = st_ff.match;
endmodule

// file: dv/host_model.sv
// host controller model driving the task-file register port
`timescale 1ns/1ps
module host_model
  import max_limit_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic [15:0] regRdData,
  output logic [3:0]       regAddr,
  output logic [15:0]      regWrData,
  output logic             regWr,
  output logic             regRd
);
  // idle bus from time zero
  initial
  begin
    regAddr   = 4'h0;
    regWrData = 16'h0000;
    regWr     = 1'b0;
    regRd     = 1'b0;
  end
  // one write cycle; released lines show the inverse of the last value
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    regAddr   <= a;
    regWrData <= v;
    regWr     <= 1'b1;
    @(posedge clk_sys);
    regWr     <= 1'b0;
    regAddr   <= ~a;
    regWrData <= ~v;
  endtask
  // one read cycle; data taken in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk_sys);
    regRd   <= 1'b0;
    regAddr <= ~a;
    @(negedge clk_sys);
    v = regRdData;
  endtask
  // task-file load, then the command write
  task automatic issue(input logic [7:0] f, sc, sn, cl, ch, hd, code);
    wr(REG_FEATURE, {8'h00, f});
    wr(REG_SECCNT, {8'h00, sc});
    wr(REG_SECNUM, {8'h00, sn});
    wr(REG_CYLLO, {8'h00, cl});
    wr(REG_CYLHI, {8'h00, ch});
    wr(REG_HEAD, {8'h00, hd});
    wr(REG_STATUS, {8'h00, code});
  endtask
  // one sector of key data, words 1 to 16 carry the key
  task automatic send_sector();
    for (int i = 0; i < SECTOR_WORDS; i++)
      wr(REG_DATA, 16'(i) ^ 16'hA5A5);
  endtask
endmodule

// file: dv/tb_max_address_limit_security.sv
// self-checking bench for the limit command interpreter
`timescale 1ns/1ps
module tb_max_address_limit_security;
  import max_limit_pkg::*;
  logic        clk_sys;
  logic        reset_n;
  logic        powerOn;
  logic [3:0]  regAddr;
  logic [15:0] regWrData;
  logic        regWr;
  logic        regRd;
  logic [15:0] regRdData;
  logic [27:0] accessAddr;
  logic        accessReq;
  logic        accessAbort;
  logic [27:0] identifyMax;
  logic        busy;
  logic [15:0] d;
  logic [27:0] keep;
  int          bad_count;
  int          n_tests;

  // inputs at time zero
  initial
  begin
    clk_sys    = 1'b0;
    reset_n    = 1'b0;
    powerOn    = 1'b0;
    accessAddr = 28'h000_0000;
    accessReq  = 1'b0;
    bad_count  = 0;
    n_tests    = 0;
  end
  // 50 ns clock
  always #25 clk_sys = ~clk_sys;

  max_address_limit_security dut (.clk_sys(clk_sys), .reset_n(reset_n), .powerOn(powerOn),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .accessAddr(accessAddr), .accessReq(accessReq),
    .accessAbort(accessAbort), .identifyMax(identifyMax), .busy(busy));
  host_model host (.clk_sys(clk_sys), .regRdData(regRdData), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd));

  // verdict and end of run
  task automatic stop_test();
    $display("mismatches %0d of %0d comparisons", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // compare one value
  task automatic chk(input logic [27:0] got, input logic [27:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait for busy to drop
  task automatic wait_done();
    int i;
    i = 0;
    @(negedge clk_sys);
    while (busy !== 1'b0 && i < 40)
    begin
      @(negedge clk_sys);
      i++;
    end
    if (busy !== 1'b0)
    begin
      bad_count++;
      stop_test();
    end
  endtask
  // command, then abort bit and error bit
  task automatic run(input logic [7:0] f, sc, sn, cl, ch, hd, code, input logic ab);
    host.issue(f, sc, sn, cl, ch, hd, code);
    wait_done();
    host.rd(REG_ERROR, d);
    chk(28'(d[ERR_ABORT_BIT]), 28'(ab));
    host.rd(REG_STATUS, d);
    chk(28'(d[STS_ERR_BIT]), 28'(ab));
  endtask
  // read-native, then a block-mode limit update
  task automatic set_lim(input logic [7:0] sc, input logic [27:0] a, input logic ab);
    run(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hE0, CMD_READ_NATIVE, 1'b0);
    run(8'h00, sc, a[7:0], a[15:8], a[23:16], {4'hE, a[27:24]}, CMD_LIMIT, ab);
  endtask
  // read a task-file byte and compare
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    host.rd(a, d);
    chk(28'(d[7:0]), 28'(exp));
  endtask
  // key-set flag and security state
  task automatic stat(input logic [2:0] exp);
    host.rd(REG_LIMSTAT, d);
    chk(28'({d[4], d[1:0]}), 28'(exp));
  endtask
  // access probe, abort seen one cycle later
  task automatic probe(input logic [27:0] a, input logic exp);
    @(posedge clk_sys);
    accessAddr <= a;
    accessReq  <= 1'b1;
    @(posedge clk_sys);
    accessReq  <= 1'b0;
    @(negedge clk_sys);
    chk(28'(accessAbort), 28'(exp));
  endtask
  // power-on or hardware reset pulse
  task automatic pulse(input bit hw);
    @(posedge clk_sys);
    if (hw)
      reset_n <= 1'b0;
    else
      powerOn <= 1'b1;
    @(posedge clk_sys);
    reset_n <= 1'b1;
    powerOn <= 1'b0;
    @(posedge clk_sys);
  endtask
  // key sub-command with its data sector, then the abort bit
  task automatic key(input logic [7:0] f, input logic ab);
    host.issue(f, 8'h00, 8'h00, 8'h00, 8'h00, 8'hE0, CMD_LIMIT);
    @(negedge clk_sys);
    chk(28'(busy), 28'h1);
    wait_done();
    host.rd(REG_STATUS, d);
    chk(28'(d[STS_REQ_BIT]), 28'h1);
    host.send_sector();
    wait_done();
    host.rd(REG_ERROR, d);
    chk(28'(d[ERR_ABORT_BIT]), 28'(ab));
  endtask

  // reset values and an unmapped read
  task automatic s_reset();
    chk(identifyMax, NATIVE_MAX_RST);
    rchk(REG_STATUS, 8'h40);
    rchk(REG_ERROR, 8'h00);
    rchk(4'hF, 8'h00);
    stat(3'b000);
  endtask
  // block-mode update ignores the feature after read-native
  task automatic s_lba();
    run(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hE0, CMD_READ_NATIVE, 1'b0);
    host.rd(REG_LIMSTAT, d);
    chk(28'(d[2]), 28'h1);
    run(FEAT_LOCK, 8'h00, 8'h34, 8'h12, 8'h05, 8'hE0, CMD_LIMIT, 1'b0);
    stat(3'b000);
    host.rd(REG_LIMSTAT, d);
    chk(28'(d[2]), 28'h0);
    chk(identifyMax, 28'h005_1234);
    rchk(REG_SECNUM, 8'h34);
    rchk(REG_CYLLO, 8'h12);
    rchk(REG_CYLHI, 8'h05);
    host.rd(REG_HEAD, d);
    chk(28'(d[3:0]), 28'h0);
    probe(28'h005_1234, 1'b0);
    probe(28'h005_1235, 1'b1);
    set_lim(8'h00, 28'h100_0000, 1'b1);
    chk(identifyMax, 28'h005_1234);
  endtask
  // cylinder mode takes cylinders only, returns maxima
  task automatic s_chs();
    run(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA0, CMD_READ_NATIVE, 1'b0);
    run(8'h00, 8'h00, 8'h77, 8'h20, 8'h00, 8'hA5, CMD_LIMIT, 1'b0);
    rchk(REG_SECNUM, MAX_SECTOR_RST);
    rchk(REG_CYLLO, 8'h20);
    rchk(REG_CYLHI, 8'h00);
    host.rd(REG_HEAD, d);
    chk(28'(d[3:0]), 28'(MAX_HEAD_RST));
  endtask
  // persistence option, offset mode and one-shot nonvolatile update
  task automatic s_nv();
    host.wr(REG_OFFMODE, 16'h0001);
    keep = identifyMax;
    set_lim(8'h01, 28'h000_0100, 1'b1);
    chk(identifyMax, keep);
    host.wr(REG_OFFMODE, 16'h0000);
    set_lim(8'h01, 28'h000_0100, 1'b0);
    set_lim(8'h01, 28'h000_0200, 1'b1);
    chk(identifyMax, 28'h000_0100);
    set_lim(8'h00, 28'h000_0300, 1'b0);
    chk(identifyMax, 28'h000_0300);
    pulse(1'b0);
    chk(identifyMax, 28'h000_0100);
    pulse(1'b1);
    set_lim(8'h01, 28'h000_0400, 1'b0);
  endtask
  // key, lock, freeze and the power cycle
  task automatic s_sec();
    key(FEAT_SET_PASS, 1'b0);
    stat(3'b100);
    run(FEAT_LOCK, 8'h00, 8'h00, 8'h00, 8'h00, 8'hE0, CMD_LIMIT, 1'b0);
    stat(3'b101);
    set_lim(8'h00, 28'h000_0500, 1'b1);
    run(FEAT_SET_PASS, 8'h00, 8'h00, 8'h00, 8'h00, 8'hE0, CMD_LIMIT, 1'b1);
    stat(3'b101);
    key(FEAT_UNLOCK, 1'b0);
    stat(3'b100);
    run(FEAT_LOCK, 8'h00, 8'h00, 8'h00, 8'h00, 8'hE0, CMD_LIMIT, 1'b0);
    stat(3'b101);
    run(FEAT_FREEZE, 8'h00, 8'h00, 8'h00, 8'h00, 8'hE0, CMD_LIMIT, 1'b0);
    stat(3'b110);
    run(FEAT_LOCK, 8'h00, 8'h00, 8'h00, 8'h00, 8'hE0, CMD_LIMIT, 1'b1);
    set_lim(8'h00, 28'h000_0500, 1'b1);
    pulse(1'b0);
    stat(3'b000);
    key(FEAT_UNLOCK, 1'b1);
  endtask

  // main sequence
  initial
  begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    s_reset();
    s_lba();
    s_chs();
    s_nv();
    s_sec();
    stop_test();
  end
endmodule
